// [logic/cco_core_objects.sv]
// Purpose: SDO server for device type, fault summary, vendor status,
//          fault history and the device name string
// Assumes: Frames arrive already filtered and synchronous to clk
// Notes: One answer frame per accepted request other than a master abort, one cycle later
//
// Operation
// RULE1: Unsupported sub-index access gets an abort frame instead of data.
// RULE2: Device type, fault summary, vendor status are read-only, sub-index 0 only, plus device type sub 1 in FD mode.
// RULE3: Device type holds profile number low, input/output presence flags high.
// RULE4: FD mode: sub 0 reads logical device count 01h, sub 1 the type.
// RULE5: Fault summary reads the live fault state, zero when no fault.
// RULE6: Vendor status always reads all zeros.
// RULE7: History keeps four 32-bit read-only entries and a writable count.
// RULE8: Count always accessible; entries only while count above zero.
// RULE9: Writing zero to the history count erases history and count.
// RULE10: Clear uses one-byte download 2F, acknowledged with 60 and echo.
// RULE11: Count read answered with one-byte upload response 4F.
// RULE12: Node 127 requests on 67F, answers on 5FF, 8-byte frames.
// RULE13: Name string longer than four bytes returned by segmented upload.
// RULE14: Count saturates at four; newest error enters at sub-index 1.
`timescale 1ns/100ps
module cco_core_objects
   import cco_pkg::*;
#(
   parameter logic [6:0] NODE_ID = 7'd127,
   parameter int NAME_LEN = 12,
   // Arbitrary neutral name text
   parameter logic [8*NAME_LEN-1:0] NAME_STR = "io8 dio node"
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic fd_mode,
   input wire logic req_valid,
   input wire logic [10:0] req_id,
   input wire logic [63:0] req_data,
   output logic rsp_valid,
   output logic [10:0] rsp_id,
   output logic [63:0] rsp_data,
   input wire logic [7:0] fault_bits,
   input wire logic err_push,
   input wire logic [31:0] err_code,
   output logic [7:0] log_count
);

   localparam logic [10:0] REQ_ID = CCO_REQ_BASE + 11'(NODE_ID);
   localparam logic [10:0] RSP_ID = CCO_RSP_BASE + 11'(NODE_ID);
   localparam logic [7:0] NAME_LEN_B = 8'(NAME_LEN);
   localparam logic [31:0] DEVTYPE_VAL = {CCO_INFO_DIN | CCO_INFO_DOUT, CCO_PROFILE_NUM};

   logic taken;
   logic [7:0] cmd;
   logic [2:0] ccs;
   logic [15:0] idx;
   logic [7:0] sub;
   logic [31:0] wval;
   logic [7:0] summary;
   logic [31:0] log_entry;
   logic log_clear;
   logic fire_nxt;
   logic [63:0] rsp_nxt;
   logic seg_act_r;
   logic seg_act_nxt;
   logic [7:0] seg_pos_r;
   logic [7:0] seg_pos_nxt;
   logic seg_tog_r;
   logic seg_tog_nxt;
   logic rsp_valid_r;
   logic [63:0] rsp_data_r;

   // ------------------------------------------------------------------
   // Request fields
   // ------------------------------------------------------------------
   assign taken = ce && req_valid && (req_id == REQ_ID); // RULE12
   assign cmd = req_data[7:0];
   assign ccs = cmd[7:5];
   assign idx = req_data[23:8];
   assign sub = req_data[31:24];
   assign wval = req_data[63:32];
   // Generic error bit follows any other fault bit
   assign summary = {fault_bits[7:1], |fault_bits}; // RULE5

   function automatic logic [63:0] f_frame(input logic [7:0] c, input logic [15:0] i,
                                           input logic [7:0] s, input logic [31:0] d);
      f_frame = {d, s, i, c};
   endfunction : f_frame

   function automatic logic [7:0] f_name_byte(input logic [7:0] p);
      logic [8*NAME_LEN-1:0] sh;
      sh = NAME_STR >> (8 * (NAME_LEN - 1 - int'(p)));
      f_name_byte = sh[7:0];
   endfunction : f_name_byte

   cco_fault_log #(
      .DEPTH(CCO_LOG_DEPTH),
      .W(32)
   ) u_log (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .push(err_push),
      .code(err_code),
      .clear(log_clear),
      .rd_sub(sub),
      .count_r(log_count),
      .rd_data(log_entry)
   );

   // ------------------------------------------------------------------
   // Object decode and answer build
   // ------------------------------------------------------------------
   always_comb begin
      logic [7:0] remain;
      logic [7:0] seg_b [7];
      remain = 8'h00;
      for (int k = 0; k < 7; k++) begin
         seg_b[k] = 8'h00;
      end
      fire_nxt = taken;
      log_clear = 1'b0;
      seg_act_nxt = seg_act_r;
      seg_pos_nxt = seg_pos_r;
      seg_tog_nxt = seg_tog_r;
      rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_BADCMD);
      if (taken) begin
         // Any request other than a segment request ends a pending string
         seg_act_nxt = 1'b0;
         unique case (ccs)
            CCO_CCS_UPLOAD: begin
               unique case (idx)
                  CCO_IDX_DEVTYPE: begin
                     if (fd_mode && sub == CCO_SUB_ZERO) begin
                        rsp_nxt = f_frame(CCO_CMD_UP_ONE, idx, sub,
                                          {24'h00_0000, CCO_LOGDEV_COUNT}); // RULE4
                     end else if (sub == (fd_mode ? CCO_SUB_ONE : CCO_SUB_ZERO)) begin
                        rsp_nxt = f_frame(CCO_CMD_UP_FOUR, idx, sub, DEVTYPE_VAL); // RULE3
                     end else begin
                        rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOSUB); // RULE1
                     end
                  end
                  CCO_IDX_FAULTSUM: begin
                     if (sub == CCO_SUB_ZERO) begin
                        rsp_nxt = f_frame(CCO_CMD_UP_ONE, idx, sub, {24'h00_0000, summary});
                     end else begin
                        rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOSUB); // RULE2
                     end
                  end
                  CCO_IDX_VENDSTAT: begin
                     if (sub == CCO_SUB_ZERO) begin
                        rsp_nxt = f_frame(CCO_CMD_UP_FOUR, idx, sub, CCO_VENDSTAT_VAL); // RULE6
                     end else begin
                        rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOSUB); // RULE2
                     end
                  end
                  CCO_IDX_FAULTLOG: begin
                     if (sub == CCO_SUB_ZERO) begin
                        rsp_nxt = f_frame(CCO_CMD_UP_ONE, idx, sub,
                                          {24'h00_0000, log_count}); // RULE11
                     end else if (sub > 8'(CCO_LOG_DEPTH)) begin
                        rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOSUB); // RULE1
                     end else if (log_count == 8'h00) begin
                        rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NODATA); // RULE8
                     end else begin
                        rsp_nxt = f_frame(CCO_CMD_UP_FOUR, idx, sub, log_entry); // RULE7
                     end
                  end
                  CCO_IDX_DEVNAME: begin
                     if (sub == CCO_SUB_ZERO) begin
                        rsp_nxt = f_frame(CCO_CMD_UP_SEG, idx, sub,
                                          {24'h00_0000, NAME_LEN_B}); // RULE13
                        seg_act_nxt = 1'b1;
                        seg_pos_nxt = 8'h00;
                        seg_tog_nxt = 1'b0;
                     end else begin
                        rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOSUB); // RULE1
                     end
                  end
                  default: begin
                     rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOOBJ);
                  end
               endcase
            end
            CCO_CCS_DOWNLOAD: begin
               if (idx == CCO_IDX_FAULTLOG && sub == CCO_SUB_ZERO) begin
                  if (cmd != CCO_CMD_DL_ONE) begin
                     rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_LENGTH); // RULE10
                  end else if (wval[7:0] != 8'h00) begin
                     rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_RANGE);
                  end else begin
                     log_clear = 1'b1; // RULE9
                     rsp_nxt = f_frame(CCO_CMD_DL_ACK, idx, sub, 32'h0000_0000); // RULE10
                  end
               end else if ((idx == CCO_IDX_DEVTYPE && (sub == CCO_SUB_ZERO
                            || (fd_mode && sub == CCO_SUB_ONE)))
                            || ((idx == CCO_IDX_FAULTSUM || idx == CCO_IDX_VENDSTAT
                            || idx == CCO_IDX_DEVNAME) && sub == CCO_SUB_ZERO)
                            || (idx == CCO_IDX_FAULTLOG && sub <= 8'(CCO_LOG_DEPTH))) begin
                  rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_READONLY); // RULE2
               end else if (idx == CCO_IDX_DEVTYPE || idx == CCO_IDX_FAULTSUM
                            || idx == CCO_IDX_VENDSTAT || idx == CCO_IDX_FAULTLOG
                            || idx == CCO_IDX_DEVNAME) begin
                  rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOSUB); // RULE1
               end else begin
                  rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_NOOBJ);
               end
            end
            CCO_CCS_SEGUP: begin
               if (!seg_act_r) begin
                  rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_BADCMD);
               end else if (cmd[4] != seg_tog_r) begin
                  rsp_nxt = f_frame(CCO_CMD_ABORT, CCO_IDX_DEVNAME, CCO_SUB_ZERO,
                                    CCO_AB_TOGGLE);
               end else begin
                  remain = NAME_LEN_B - seg_pos_r;
                  for (int k = 0; k < 7; k++) begin
                     if (8'(k) < remain) begin
                        seg_b[k] = f_name_byte(seg_pos_r + 8'(k));
                     end
                  end
                  if (remain <= 8'd7) begin
                     rsp_nxt[7:0] = {3'b000, seg_tog_r, 3'(8'd7 - remain), 1'b1}; // RULE13
                  end else begin
                     rsp_nxt[7:0] = {3'b000, seg_tog_r, 3'b000, 1'b0}; // RULE13
                     seg_act_nxt = 1'b1;
                     seg_pos_nxt = seg_pos_r + 8'd7;
                     seg_tog_nxt = ~seg_tog_r;
                  end
                  rsp_nxt[63:8] = {seg_b[6], seg_b[5], seg_b[4], seg_b[3], seg_b[2],
                                   seg_b[1], seg_b[0]};
               end
            end
            CCO_CCS_ABORT: begin
               // Master abort: drop the transfer silently
               fire_nxt = 1'b0;
            end
            default: begin
               rsp_nxt = f_frame(CCO_CMD_ABORT, idx, sub, CCO_AB_BADCMD);
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Segmented transfer state
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seg_act_r <= 1'b0;
         seg_pos_r <= 8'h00;
         seg_tog_r <= 1'b0;
      end else if (ce) begin
         seg_act_r <= seg_act_nxt;
         seg_pos_r <= seg_pos_nxt;
         seg_tog_r <= seg_tog_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Answer frame
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r <= 64'h0000_0000_0000_0000;
      end else if (ce) begin
         rsp_valid_r <= fire_nxt; // RULE12
         if (fire_nxt) begin
            rsp_data_r <= rsp_nxt;
         end
      end
   end

   assign rsp_valid = rsp_valid_r;
   assign rsp_data = rsp_data_r;
   assign rsp_id = RSP_ID; // RULE12

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seg_start_s;
      taken && ccs == CCO_CCS_UPLOAD && idx == CCO_IDX_DEVNAME && sub == CCO_SUB_ZERO;
   endsequence
   sequence seg_ask_s;
      taken && ccs == CCO_CCS_SEGUP && cmd[4] == 1'b0 && seg_act_r && seg_pos_r == 8'h00;
   endsequence

   answer_timing_a: assert property ((taken && ccs != CCO_CCS_ABORT) |=> rsp_valid
      && rsp_id == 11'h5FF) // RULE12
      else $error("no answer one cycle after a request");
   summary_sub_a: assert property ((taken && ccs == CCO_CCS_UPLOAD && idx == CCO_IDX_FAULTSUM
      && sub != CCO_SUB_ZERO) |=> rsp_data[7:0] == CCO_CMD_ABORT) // RULE1
      else $error("bad sub-index answered with data");
   vendstat_ro_a: assert property ((taken && ccs == CCO_CCS_DOWNLOAD
      && idx == CCO_IDX_VENDSTAT && sub == CCO_SUB_ZERO)
      |=> rsp_data[63:32] == CCO_AB_READONLY) // RULE2
      else $error("read-only object accepted a write");
   devtype_val_a: assert property ((taken && ccs == CCO_CCS_UPLOAD && !fd_mode
      && idx == CCO_IDX_DEVTYPE && sub == CCO_SUB_ZERO)
      |=> rsp_data[7:0] == 8'h43 && rsp_data[47:32] == CCO_PROFILE_NUM
      && rsp_data[63:48] == 16'h0003) // RULE3
      else $error("device type value wrong");
   fd_count_a: assert property ((taken && ccs == CCO_CCS_UPLOAD && fd_mode
      && idx == CCO_IDX_DEVTYPE && sub == CCO_SUB_ZERO)
      |=> rsp_data[7:0] == 8'h4F && rsp_data[39:32] == 8'h01) // RULE4
      else $error("logical device count wrong");
   summary_zero_a: assert property ((taken && ccs == CCO_CCS_UPLOAD && fault_bits == 8'h00
      && idx == CCO_IDX_FAULTSUM && sub == CCO_SUB_ZERO) |=> rsp_data[39:32] == 8'h00) // RULE5
      else $error("fault summary not zero without faults");
   vendstat_zero_a: assert property ((taken && ccs == CCO_CCS_UPLOAD
      && idx == CCO_IDX_VENDSTAT && sub == CCO_SUB_ZERO)
      |=> rsp_data[7:0] == 8'h43 && rsp_data[63:32] == 32'h0000_0000) // RULE6
      else $error("vendor status not zero");
   entry_gate_a: assert property ((taken && ccs == CCO_CCS_UPLOAD && idx == CCO_IDX_FAULTLOG
      && sub == CCO_SUB_ONE && log_count == 8'h00) |=> rsp_data[7:0] == CCO_CMD_ABORT) // RULE8
      else $error("empty history entry answered with data");
   log_clear_a: assert property ((taken && cmd == 8'h2F && idx == CCO_IDX_FAULTLOG
      && sub == CCO_SUB_ZERO && wval[7:0] == 8'h00 && !err_push)
      |=> rsp_data[31:0] == 32'h0010_0360 && log_count == 8'h00) // RULE10
      else $error("history clear not acknowledged");
   count_read_a: assert property ((taken && ccs == CCO_CCS_UPLOAD && idx == CCO_IDX_FAULTLOG
      && sub == CCO_SUB_ZERO) |=> rsp_data[7:0] == 8'h4F
      && rsp_data[39:32] == $past(log_count)) // RULE11
      else $error("count read answer wrong");
   seg_first_a: assert property (seg_start_s ##[1:8] seg_ask_s
      |=> rsp_data[7:0] == 8'h00 && rsp_data[15:8] == NAME_STR[8*NAME_LEN-1 -: 8]) // RULE13
      else $error("first name segment wrong");

endmodule : cco_core_objects

// [logic/cco_fault_log.sv]
// Purpose: Four-deep history of recorded fault codes with a saturating count
// Assumes: push and clear come from logic on the same clock
// Notes: A push in the clear cycle lands after the clear
`timescale 1ns/100ps
module cco_fault_log
   import cco_pkg::*;
#(
   parameter int DEPTH = CCO_LOG_DEPTH,
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic push,
   input wire logic [W-1:0] code,
   input wire logic clear,
   input wire logic [7:0] rd_sub,
   output logic [7:0] count_r,
   output logic [W-1:0] rd_data
);

   logic [W-1:0] entry_r [DEPTH];

   // ------------------------------------------------------------------
   // Entry storage: newest at sub-index 1
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            entry_r[i] <= W'(CCO_LOG_ENTRY_RST);
         end
      end else if (ce) begin
         if (push) begin
            entry_r[0] <= code; // RULE14
            for (int i = 1; i < DEPTH; i++) begin
               entry_r[i] <= clear ? W'(CCO_LOG_ENTRY_RST) : entry_r[i-1]; // RULE14
            end
         end else if (clear) begin
            for (int i = 0; i < DEPTH; i++) begin
               entry_r[i] <= W'(CCO_LOG_ENTRY_RST); // RULE9
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Count, saturating at the depth
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= CCO_LOG_COUNT_RST;
      end else if (ce) begin
         if (push) begin
            // Event wins over clear: the fresh fault is kept
            if (clear) begin
               count_r <= 8'h01;
            end else if (count_r < 8'(DEPTH)) begin
               count_r <= count_r + 8'h01; // RULE14
            end
         end else if (clear) begin
            count_r <= CCO_LOG_COUNT_RST; // RULE9
         end
      end
   end

   always_comb begin
      rd_data = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (rd_sub == 8'(i + 1)) begin
            rd_data = entry_r[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   count_sat_a: assert property ((ce && push && !clear && count_r == 8'(DEPTH))
      |=> count_r == 8'(DEPTH)) // RULE14
      else $error("fault count left its ceiling");
   count_clear_a: assert property ((ce && clear && !push) |=> count_r == 8'h00
      && entry_r[0] == '0) // RULE9
      else $error("history clear did not empty the log");
   newest_first_a: assert property ((ce && push) |=> entry_r[0] == $past(code)) // RULE14
      else $error("newest fault not at sub-index one");

endmodule : cco_fault_log

// [logic/cco_pkg.sv]
// Purpose: Shared constants for the communication-profile object block
// Assumes: Expedited and segmented SDO framing, 8-byte frames
// Notes: Request byte 1 sits in data bits 7:0, byte 8 in bits 63:56
package cco_pkg;

   // ------------------------------------------------------------------
   // Object indices and sub-indices
   // ------------------------------------------------------------------
   localparam logic [15:0] CCO_IDX_DEVTYPE = 16'h1000;
   localparam logic [15:0] CCO_IDX_FAULTSUM = 16'h1001;
   localparam logic [15:0] CCO_IDX_VENDSTAT = 16'h1002;
   localparam logic [15:0] CCO_IDX_FAULTLOG = 16'h1003;
   localparam logic [15:0] CCO_IDX_DEVNAME = 16'h1008;
   localparam logic [7:0] CCO_SUB_ZERO = 8'h00;
   localparam logic [7:0] CCO_SUB_ONE = 8'h01;

   // ------------------------------------------------------------------
   // Values after reset and fixed contents
   // ------------------------------------------------------------------
   // Arbitrary value, stands in for the profile code
   localparam logic [15:0] CCO_PROFILE_NUM = 16'h05A3;
   localparam logic [15:0] CCO_INFO_DIN = 16'h0001;
   localparam logic [15:0] CCO_INFO_DOUT = 16'h0002;
   localparam logic [7:0] CCO_LOGDEV_COUNT = 8'h01;
   localparam logic [31:0] CCO_VENDSTAT_VAL = 32'h0000_0000;
   localparam logic [7:0] CCO_LOG_COUNT_RST = 8'h00;
   localparam logic [31:0] CCO_LOG_ENTRY_RST = 32'h0000_0000;
   localparam int CCO_LOG_DEPTH = 4;

   // ------------------------------------------------------------------
   // Frame identifiers
   // ------------------------------------------------------------------
   localparam logic [10:0] CCO_REQ_BASE = 11'h600;
   localparam logic [10:0] CCO_RSP_BASE = 11'h580;

   // ------------------------------------------------------------------
   // Command specifiers
   // ------------------------------------------------------------------
   localparam logic [2:0] CCO_CCS_DOWNLOAD = 3'b001;
   localparam logic [2:0] CCO_CCS_UPLOAD = 3'b010;
   localparam logic [2:0] CCO_CCS_SEGUP = 3'b011;
   localparam logic [2:0] CCO_CCS_ABORT = 3'b100;
   localparam logic [7:0] CCO_CMD_DL_ONE = 8'h2F;
   localparam logic [7:0] CCO_CMD_DL_ACK = 8'h60;
   localparam logic [7:0] CCO_CMD_UP_ONE = 8'h4F;
   localparam logic [7:0] CCO_CMD_UP_FOUR = 8'h43;
   localparam logic [7:0] CCO_CMD_UP_SEG = 8'h41;
   localparam logic [7:0] CCO_CMD_ABORT = 8'h80;

   // ------------------------------------------------------------------
   // Abort codes
   // ------------------------------------------------------------------
   localparam logic [31:0] CCO_AB_TOGGLE = 32'h0503_0000;
   localparam logic [31:0] CCO_AB_BADCMD = 32'h0504_0001;
   localparam logic [31:0] CCO_AB_READONLY = 32'h0601_0002;
   localparam logic [31:0] CCO_AB_NOOBJ = 32'h0602_0000;
   localparam logic [31:0] CCO_AB_LENGTH = 32'h0607_0010;
   localparam logic [31:0] CCO_AB_NOSUB = 32'h0609_0011;
   localparam logic [31:0] CCO_AB_RANGE = 32'h0609_0030;
   localparam logic [31:0] CCO_AB_NODATA = 32'h0800_0024;

endpackage : cco_pkg

// [tb/cco_master.sv]
// Purpose: Network master model, one request frame per send pulse
// Assumes: send is a one-cycle pulse from the bench
// Notes: Idle lines toggle each cycle between the last frame and its inverse
`timescale 1ns/100ps
module cco_master (
   input wire logic clk,
   input wire logic send,
   input wire logic [10:0] id,
   input wire logic [63:0] frame,
   output logic req_valid,
   output logic [10:0] req_id,
   output logic [63:0] req_data
);
   initial begin
      req_valid = 1'b0;
      req_id = 11'h000;
      req_data = 64'h0000_0000_0000_0000;
   end
   always @(posedge clk) begin
      req_valid <= send;
      req_id <= send ? id : ~req_id;
      req_data <= send ? frame : ~req_data;
   end
endmodule : cco_master

// [tb/testbench.sv]
// Purpose: Self-checking bench for the object block
// Assumes: One answer per accepted request other than a master abort
// Notes: History reference is a queue, newest first
`timescale 1ns/100ps
module testbench;
   import cco_pkg::*;
   localparam logic [95:0] NM = "io8 dio node";
   localparam logic [31:0] DT = {16'h0003, CCO_PROFILE_NUM};
   logic clk = 1'b0, rst = 1'b1, fd = 1'b0, send = 1'b0, ep = 1'b0, ce = 1'b1;
   logic [10:0] id = 11'h67F, req_id, rsp_id;
   logic [63:0] frame = '0, req_data, rsp_data, got;
   logic [55:0] seg;
   logic [31:0] code = '0;
   logic [31:0] log_q[$];
   logic [7:0] fb = 8'h00, log_count;
   logic req_valid, rsp_valid;
   int num_errors = 0, num_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   cco_master u_mst (.clk(clk), .send(send), .id(id), .frame(frame), .req_valid(req_valid),
      .req_id(req_id), .req_data(req_data));
   cco_core_objects #(.NODE_ID(7'd127), .NAME_LEN(12), .NAME_STR(NM)) u_dut (.clk(clk),
      .rst(rst), .ce(ce), .fd_mode(fd), .req_valid(req_valid), .req_id(req_id),
      .req_data(req_data), .rsp_valid(rsp_valid), .rsp_id(rsp_id), .rsp_data(rsp_data),
      .fault_bits(fb), .err_push(ep), .err_code(code), .log_count(log_count));
   function automatic logic [63:0] fr(logic [7:0] c, logic [15:0] x, logic [7:0] s,
      logic [31:0] d);
      return {d, s, x, c};
   endfunction : fr
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk
   // Exactly one answer expected unless want is zero
   task automatic req(input logic [63:0] f, input logic [63:0] e, input int want = 1);
      int cnt = 0;
      @(posedge clk);
      send <= 1'b1;
      frame <= f;
      @(posedge clk);
      send <= 1'b0;
      repeat (4) begin
         @(negedge clk);
         if (rsp_valid === 1'b1) begin
            cnt++;
            got = rsp_data;
         end
      end
      chk(64'(want), 64'(cnt));
      if (want == 1) chk(e, got);
   endtask : req
   task automatic push();
      logic [31:0] c = $urandom;
      @(posedge clk);
      ep <= 1'b1;
      code <= c;
      @(posedge clk);
      ep <= 1'b0;
      log_q.push_front(c);
      if (log_q.size() > 4) void'(log_q.pop_back());
   endtask : push
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      void'($urandom(41732));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      req(fr(8'h40, 16'h1000, 0, 0), fr(8'h43, 16'h1000, 0, DT));
      chk(64'h5FF, 64'(rsp_id));
      req(fr(8'h40, 16'h1000, 1, 0), fr(8'h80, 16'h1000, 1, CCO_AB_NOSUB));
      req(fr(8'h40, 16'h1005, 0, 0), fr(8'h80, 16'h1005, 0, CCO_AB_NOOBJ));
      req(fr(8'h23, 16'h1002, 0, 1), fr(8'h80, 16'h1002, 0, CCO_AB_READONLY));
      req(fr(8'h40, 16'h1002, 0, 0), fr(8'h43, 16'h1002, 0, 0));
      req(fr(8'h40, 16'h1001, 0, 0), fr(8'h4F, 16'h1001, 0, 0));
      @(posedge clk) fb <= 8'($urandom_range(255, 1));
      @(negedge clk);
      req(fr(8'h40, 16'h1001, 0, 0), fr(8'h4F, 16'h1001, 0, {24'h0, fb[7:1], 1'b1}));
      chk(64'h1, {63'h0, got[32]});
      req(fr(8'h40, 16'h1001, 1, 0), fr(8'h80, 16'h1001, 1, CCO_AB_NOSUB));
      @(posedge clk) fd <= 1'b1;
      req(fr(8'h40, 16'h1000, 0, 0), fr(8'h4F, 16'h1000, 0, 1));
      req(fr(8'h40, 16'h1000, 1, 0), fr(8'h43, 16'h1000, 1, DT));
      req(fr(8'h40, 16'h1000, 2, 0), fr(8'h80, 16'h1000, 2, CCO_AB_NOSUB));
      @(posedge clk) fd <= 1'b0;
      req(fr(8'h40, 16'h1003, 0, 0), fr(8'h4F, 16'h1003, 0, 0));
      req(fr(8'h40, 16'h1003, 1, 0), fr(8'h80, 16'h1003, 1, CCO_AB_NODATA));
      repeat (5) push();
      req(fr(8'h40, 16'h1003, 0, 0), fr(8'h4F, 16'h1003, 0, 4));
      for (int s = 1; s <= 4; s++)
         req(fr(8'h40, 16'h1003, 8'(s), 0), fr(8'h43, 16'h1003, 8'(s), log_q[s-1]));
      req(fr(8'h40, 16'h1003, 5, 0), fr(8'h80, 16'h1003, 5, CCO_AB_NOSUB));
      req(fr(8'h23, 16'h1003, 1, 0), fr(8'h80, 16'h1003, 1, CCO_AB_READONLY));
      req(fr(8'h2B, 16'h1003, 0, 0), fr(8'h80, 16'h1003, 0, CCO_AB_LENGTH));
      req(fr(8'h2F, 16'h1003, 0, 3), fr(8'h80, 16'h1003, 0, CCO_AB_RANGE));
      req(fr(8'h2F, 16'h1003, 0, 0), fr(8'h60, 16'h1003, 0, 0));
      chk(64'h0, 64'(log_count));
      req(fr(8'h40, 16'h1003, 1, 0), fr(8'h80, 16'h1003, 1, CCO_AB_NODATA));
      @(posedge clk) id <= 11'h601;
      req(fr(8'h40, 16'h1000, 0, 0), 0, 0);
      @(posedge clk) id <= 11'h67F;
      req(fr(8'h80, 16'h1000, 0, 0), 0, 0);
      @(posedge clk) ce <= 1'b0;
      req(fr(8'h40, 16'h1000, 0, 0), 0, 0);
      @(posedge clk) ce <= 1'b1;
      req(fr(8'h40, 16'h1008, 0, 0), fr(8'h41, 16'h1008, 0, 12));
      for (int k = 0; k < 2; k++) begin
         for (int j = 0; j < 7; j++)
            seg[8*j+:8] = (7*k + j < 12) ? NM[8*(11-7*k-j)+:8] : 8'h00;
         req({56'h0, k ? 8'h70 : 8'h60}, {seg, k ? 8'h15 : 8'h00});
      end
      req({56'h0, 8'h60}, fr(8'h80, 16'h0000, 0, CCO_AB_BADCMD));
      req(fr(8'h40, 16'h1008, 0, 0), fr(8'h41, 16'h1008, 0, 12));
      req({56'h0, 8'h70}, fr(8'h80, 16'h1008, 0, CCO_AB_TOGGLE));
      test_done();
   end
endmodule : testbench
